// ---- tpb_core.sv ----
// timer pulse module core: counter, buffered period and compare, flags, requests
// Function
// - stopped counter: period write acts at once
// - edge mode: period loads at limit-to-zero wrap
// - center mode: period loads at limit-to-limit-minus-one
// - stopped counter: compare write acts at once
// - compare mode: value loads at next counter step, increment or wrap
// - edge pulse: compare loads at wrap
// - center pulse: compare loads at limit downstep
// - dma request equals dma enable and flag
// - dma off: flag cleared by software one
// - dma on: dma done also clears flag
// - reset: counters zero, stopped, interrupts low
// - reset: capture mode, outputs zero, pins released
// - overflow irq is enable and flag
// - channel irq is enable and flag
// - center select chooses up-down counting
// - compare mode: center off, mode one
// - mode two: center or edge pulse
// - up count: overflow flag at limit wrap
`timescale 1ns/100ps
`default_nettype none
module tpb_core
  #(
  parameter int NCH = tpb_pkg::TPB_NCH,
  parameter int PRE_W = tpb_pkg::TPB_PRE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // counter control
  input wire logic [1:0] counter_clock_select,
  input wire logic center_align_select,
  input wire logic [PRE_W-1:0] prescale,
  input wire logic overflow_irq_enable,
  input wire logic overflow_clear,
  // period limit write
  input wire tpb_pkg::tpb_wr_t period_wr,
  // channels
  input wire tpb_pkg::tpb_chan_cfg_t [NCH-1:0] chan_cfg,
  input wire tpb_pkg::tpb_wr_t [NCH-1:0] cmp_wr,
  input wire logic [NCH-1:0] flag_clear,
  input wire logic [NCH-1:0] dma_done,
  // state and requests
  output logic [15:0] count,
  output logic [15:0] period_limit,
  output logic [NCH-1:0][15:0] channel_compare_value,
  output logic overflow_flag,
  output logic overflow_irq,
  output logic [NCH-1:0] channel_event_flag,
  output logic [NCH-1:0] channel_irq,
  output logic [NCH-1:0] dma_req,
  output logic [NCH-1:0] chan_out,
  output logic [NCH-1:0] chan_oe_n
);
  import tpb_pkg::*;
  initial begin
    if (NCH < 1 || NCH > 8) $error("tpb_core: channel count out of range");
    if (PRE_W < 1 || PRE_W > 7) $error("tpb_core: prescale width out of range");
  end
  logic [127:0] pre_cnt;
  logic [127:0] pre_limit;
  logic down;
  logic [NCH-1:0] match;
  logic [NCH-1:0] next_flag;
  logic [NCH-1:0] next_out;
  // level driven at a match: only a center down-count match drives the active level
  function automatic logic match_level(input logic lo_true, input logic center, input logic dn);
    match_level = (center && dn) ? !lo_true : lo_true;
  endfunction : match_level
  // counter run decode
  wire running = (counter_clock_select != TPB_CLK_STOP);
  assign pre_limit = (128'h1 << prescale) - 128'h1;
  wire tick = running && (pre_cnt == pre_limit);
  wire at_limit = (count == period_limit);
  wire wrap = tick && !center_align_select && at_limit;
  wire turn = tick && center_align_select && at_limit && !down;
  wire ovf_event = wrap || turn;
  wire [15:0] next_count = center_align_select ?
    ((down || at_limit) ? count - 16'h0001 : count + 16'h0001) :
    (at_limit ? TPB_RST_COUNT : count + 16'h0001);
  // prescaler and counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt <= '0;
      count <= TPB_RST_COUNT;
      down <= 1'b0;
    end else if (tick) begin
      pre_cnt <= '0;
      count <= next_count;
      if (center_align_select)
        down <= (at_limit || down) && (count != 16'h0001);
      else
        down <= 1'b0;
    end else if (running) begin
      pre_cnt <= pre_cnt + 128'h1;
    end
  end
  // period limit buffer: update at wrap or at top turn
  tpb_buf_reg #(.W(16), .RST(TPB_RST_PERIOD)) u_period (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr(period_wr.wr),
    .wr_data(period_wr.data),
    .direct(!running),
    .update(ovf_event),
    .active(period_limit)
  );
  // overflow flag: set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_flag <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      overflow_flag <= ovf_event | (overflow_flag & ~overflow_clear);
      overflow_irq <= overflow_irq_enable & (ovf_event | (overflow_flag & ~overflow_clear));
    end
  end
  // per-channel compare, flag, output
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire compare_mode = !center_align_select &&
        chan_cfg[g].channel_mode_select == TPB_MODE_COMPARE;
      wire pulse_mode = chan_cfg[g].channel_mode_select == TPB_MODE_PULSE;
      wire cmp_upd = compare_mode ? tick : (pulse_mode ? ovf_event : 1'b0);
      wire cmp_wr_ok = cmp_wr[g].wr &&
        chan_cfg[g].channel_mode_select != TPB_MODE_CAPTURE;
      tpb_buf_reg #(.W(16), .RST(TPB_RST_CMP)) u_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(cmp_wr_ok),
        .wr_data(cmp_wr[g].data),
        .direct(!running),
        .update(cmp_upd),
        .active(channel_compare_value[g])
      );
      assign match[g] = tick && (count == channel_compare_value[g]) &&
        (compare_mode || pulse_mode);
      wire clr = flag_clear[g] || (chan_cfg[g].dma_enable && dma_done[g]);
      assign next_flag[g] = match[g] | (channel_event_flag[g] & ~clr);
      wire lo_true = chan_cfg[g].edge_level_select[0];
      assign next_out[g] = !pulse_mode ? chan_out[g] :
        (!center_align_select && wrap) ? !lo_true :
        (match[g] ? match_level(lo_true, center_align_select, down) : chan_out[g]);
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          channel_event_flag[g] <= 1'b0;
          channel_irq[g] <= 1'b0;
          dma_req[g] <= 1'b0;
          chan_out[g] <= 1'b0;
          chan_oe_n[g] <= 1'b1;
        end else begin
          channel_event_flag[g] <= next_flag[g];
          channel_irq[g] <= chan_cfg[g].channel_irq_enable & next_flag[g];
          dma_req[g] <= chan_cfg[g].dma_enable & next_flag[g];
          chan_out[g] <= next_out[g];
          chan_oe_n[g] <= !(pulse_mode && chan_cfg[g].edge_level_select != TPB_RST_EDGE);
        end
      end
    end
  endgenerate
  // checks
  ovf_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    overflow_irq == ($past(overflow_irq_enable) && overflow_flag))
    else $error("overflow irq mismatch");
  dma_req_a: assert property (@(posedge clk) disable iff (sys_rst)
    dma_req[0] |-> channel_event_flag[0])
    else $error("dma request without flag");
  ch_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    channel_irq[0] |-> channel_event_flag[0])
    else $error("channel irq without flag");
  wrap_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrap |=> overflow_flag && count == 16'h0000)
    else $error("wrap did not set overflow");
  stop_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running |=> count == $past(count))
    else $error("counter moved while stopped");
  flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    channel_event_flag[0] && !flag_clear[0] && !chan_cfg[0].dma_enable
    |=> channel_event_flag[0])
    else $error("flag lost without clear");
  direct_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running && period_wr.wr |=> period_limit == $past(period_wr.data))
    else $error("stopped period write not direct");
  dma_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    chan_cfg[0].dma_enable && dma_done[0] && !match[0] |=> !channel_event_flag[0])
    else $error("dma done did not clear flag");
  // exact request levels, holds between update points, counting direction
  dma_exact_a: assert property (@(posedge clk) disable iff (sys_rst)
    dma_req[0] == ($past(chan_cfg[0].dma_enable) && channel_event_flag[0]))
    else $error("dma request level mismatch");
  irq_exact_a: assert property (@(posedge clk) disable iff (sys_rst)
    channel_irq[0] == ($past(chan_cfg[0].channel_irq_enable) && channel_event_flag[0]))
    else $error("channel irq level mismatch");
  period_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && !ovf_event |=> period_limit == $past(period_limit))
    else $error("period changed off its update point");
  cmp_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && !tick |=> channel_compare_value[0] == $past(channel_compare_value[0]))
    else $error("compare changed between counter steps");
  cmp_direct_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running && cmp_wr[0].wr && chan_cfg[0].channel_mode_select != TPB_MODE_CAPTURE
    |=> channel_compare_value[0] == $past(cmp_wr[0].data))
    else $error("stopped compare write not direct");
  sw_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    flag_clear[0] && !match[0] |=> !channel_event_flag[0])
    else $error("software clear did not clear flag");
  up_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick && !center_align_select && !at_limit |=> count == $past(count) + 16'h0001)
    else $error("up count step wrong");
  turn_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
    turn |=> overflow_flag && down && count == $past(count) - 16'h0001)
    else $error("top turn did not step down");
  pins_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    chan_cfg[0].edge_level_select == TPB_RST_EDGE |=> chan_oe_n[0])
    else $error("pin driven with edge level select zero");
  wrap_c: cover property (@(posedge clk) wrap);
  turn_c: cover property (@(posedge clk) turn);
  dma_c: cover property (@(posedge clk) dma_req[0] ##1 dma_done[0]);
  down_c: cover property (@(posedge clk) turn ##1 down);
  out_rise_c: cover property (@(posedge clk) $rose(chan_out[1]));
endmodule : tpb_core
`default_nettype wire

// ---- tpb_pkg.sv ----
// package: constants and carrier types for the timer pulse buffer block
package tpb_pkg;
  localparam int TPB_CNT_W = 16;
  localparam int TPB_NCH = 2;
  localparam int TPB_PRE_W = 3;
  // counter clock select codes
  localparam logic [1:0] TPB_CLK_STOP = 2'h0;
  // channel mode select codes
  localparam logic [1:0] TPB_MODE_CAPTURE = 2'h0;
  localparam logic [1:0] TPB_MODE_COMPARE = 2'h1;
  localparam logic [1:0] TPB_MODE_PULSE = 2'h2;
  // reset values
  localparam logic [15:0] TPB_RST_COUNT = 16'h0000;
  localparam logic [15:0] TPB_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] TPB_RST_CMP = 16'h0000;
  localparam logic [1:0] TPB_RST_EDGE = 2'h0;
  // per-channel software controls
  typedef struct packed {
    logic [1:0] channel_mode_select;
    logic [1:0] edge_level_select;
    logic channel_irq_enable;
    logic dma_enable;
  } tpb_chan_cfg_t;
  // write strobe with data, for the period limit and per-channel compare
  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } tpb_wr_t;
endpackage : tpb_pkg

// ---- tpb_buf_reg.sv ----
// buffered register: pending value loads into the active value at an update point
`timescale 1ns/100ps
`default_nettype none
module tpb_buf_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // write side
  input wire logic wr,
  input wire logic [W-1:0] wr_data,
  input wire logic direct,
  input wire logic update,
  // active value
  output logic [W-1:0] active
);
  logic [W-1:0] pending;
  logic pend_valid;
  initial begin
    if (W < 1) $error("tpb_buf_reg: width must be positive");
  end
  // a later write replaces the pending value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= RST;
      pend_valid <= 1'b0;
    end else if (wr && !direct) begin
      pending <= wr_data;
      pend_valid <= 1'b1;
    end else if (update || direct) begin
      pend_valid <= 1'b0;
    end
  end
  // active value: direct on stopped counter, else at update point
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active <= RST;
    end else if (wr && direct) begin
      active <= wr_data;
    end else if (update && pend_valid) begin
      active <= pending;
    end
  end
endmodule : tpb_buf_reg
`default_nettype wire

// ---- tpb_dma_model.sv ----
// dma controller model answering channel requests with transfer done
`timescale 1ns/100ps
`default_nettype none
module tpb_dma_model #(
  parameter int NCH = 2,
  parameter int DELAY = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request and answer
  input wire logic [NCH-1:0] dma_req,
  output logic [NCH-1:0] dma_done
);
  logic [NCH-1:0][3:0] wait_cnt;
  // one done pulse per request after a fixed wait
  always_ff @(posedge clk or posedge sys_rst) begin
    for (int i = 0; i < NCH; i++) begin
      if (sys_rst) begin
        wait_cnt[i] <= 4'h0;
        dma_done[i] <= 1'b0;
      end else begin
        dma_done[i] <= dma_req[i] && !dma_done[i] && wait_cnt[i] == DELAY;
        wait_cnt[i] <= (dma_req[i] && wait_cnt[i] != DELAY) ? wait_cnt[i] + 4'h1 : 4'h0;
      end
    end
  end
endmodule : tpb_dma_model
`default_nettype wire

// ---- testbench.sv ----
// testbench for the timer pulse buffer core
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tpb_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] ccs = 2'h0;
  logic cas = 1'b0;
  logic [2:0] pre = 3'h0;
  logic oie = 1'b0;
  logic oclr = 1'b0;
  tpb_wr_t pwr = '0;
  tpb_chan_cfg_t [1:0] cfg = '0;
  tpb_wr_t [1:0] cwr = '0;
  logic [1:0] fclr = 2'h0;
  logic [1:0] done;
  logic [15:0] count, plim;
  logic [1:0][15:0] cmpv;
  logic ovf, ovf_irq;
  logic [1:0] flag, ch_irq, req, cout, coe_n;
  int err_total = 0;
  int check_count = 0;
  // clock and design
  always #50 clk = ~clk;
  tpb_core i_tpb_core (.clk(clk), .sys_rst(sys_rst), .counter_clock_select(ccs),
    .center_align_select(cas), .prescale(pre), .overflow_irq_enable(oie),
    .overflow_clear(oclr), .period_wr(pwr), .chan_cfg(cfg), .cmp_wr(cwr), .flag_clear(fclr),
    .dma_done(done), .count(count), .period_limit(plim), .channel_compare_value(cmpv),
    .overflow_flag(ovf), .overflow_irq(ovf_irq), .channel_event_flag(flag),
    .channel_irq(ch_irq), .dma_req(req), .chan_out(cout), .chan_oe_n(coe_n));
  tpb_dma_model i_tpb_dma_model (.clk(clk), .sys_rst(sys_rst), .dma_req(req), .dma_done(done));
  // shared helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic do_reset();
    sys_rst = 1'b1;
    {ccs, cas, pre, oie} = '0;
    cfg = '0;
    tick(5);
    sys_rst = 1'b0;
    tick(1);
  endtask : do_reset
  task automatic wr_period(input logic [15:0] d);
    pwr = '{1'b1, d};
    tick(1);
    pwr.wr = 1'b0;
  endtask : wr_period
  task automatic wr_cmp(input int ch, input logic [15:0] d);
    cwr[ch] = '{1'b1, d};
    tick(1);
    cwr[ch].wr = 1'b0;
  endtask : wr_cmp
  // reset state, stopped writes, capture refusal
  task automatic t_reset();
    do_reset();
    chk("count", TPB_RST_COUNT, count);
    chk("flags", 16'h0000, {10'h000, ovf, ovf_irq, flag, ch_irq});
    chk("pins", 16'h0003, {12'h000, cout, coe_n});
    wr_cmp(0, 16'h1234);
    chk("cmp0", TPB_RST_CMP, cmpv[0]);
    cfg[1].channel_mode_select = TPB_MODE_COMPARE;
    wr_cmp(1, 16'h0003);
    chk("cmp1", 16'h0003, cmpv[1]);
    wr_period(16'h0005);
    chk("period", 16'h0005, plim);
    $display("test reset done");
  endtask : t_reset
  // up counting with buffered writes
  task automatic t_edge();
    do_reset();
    oie = 1'b1;
    cfg[0].channel_mode_select = TPB_MODE_COMPARE;
    cfg[1].channel_mode_select = TPB_MODE_PULSE;
    cfg[1].edge_level_select = 2'h2;
    wr_period(16'h0008);
    ccs = 2'h1;
    wr_cmp(0, 16'h0004);
    chk("cmp0", TPB_RST_CMP, cmpv[0]);
    wr_cmp(1, 16'h0002);
    chk("cmp0", 16'h0004, cmpv[0]);
    chk("cmp1", 16'h0000, cmpv[1]);
    wr_period(16'h0009);
    chk("period", 16'h0008, plim);
    for (int i = 0; i < 40 && ovf !== 1'b1; i++) tick(1);
    chk("period", 16'h0009, plim);
    chk("cmp1", 16'h0002, cmpv[1]);
    chk("count", 16'h0000, count);
    chk("ovf irq", 16'h0001, {15'h0000, ovf_irq});
    chk("pins", 16'h0009, {12'h000, cout, coe_n});
    oclr = 1'b1;
    tick(1);
    oclr = 1'b0;
    chk("ovf", 16'h0000, {14'h0000, ovf, ovf_irq});
    tick(2);
    chk("pins", 16'h0001, {12'h000, cout, coe_n});
    $display("test edge done");
  endtask : t_edge
  // up-down counting loads at the top turn
  task automatic t_center();
    do_reset();
    cas = 1'b1;
    cfg[1].channel_mode_select = TPB_MODE_PULSE;
    wr_period(16'h0004);
    ccs = 2'h1;
    wr_cmp(1, 16'h0002);
    chk("cmp1", 16'h0000, cmpv[1]);
    wr_period(16'h0006);
    for (int i = 0; i < 20 && count !== 16'h0004; i++) tick(1);
    tick(1);
    chk("count", 16'h0003, count);
    chk("period", 16'h0006, plim);
    chk("cmp1", 16'h0002, cmpv[1]);
    $display("test center done");
  endtask : t_center
  // dma request, interrupt and flag clearing
  task automatic t_dma();
    do_reset();
    cfg[0] = '{TPB_MODE_COMPARE, 2'h0, 1'b0, 1'b1};
    cfg[1] = '{TPB_MODE_COMPARE, 2'h0, 1'b1, 1'b0};
    wr_period(16'h0005);
    wr_cmp(0, 16'h0002);
    wr_cmp(1, 16'h0002);
    pre = 3'h1;
    ccs = 2'h1;
    for (int i = 0; i < 20 && req[0] !== 1'b1; i++) tick(1);
    chk("flag req irq", 16'h0036, {10'h000, flag, req, ch_irq});
    for (int i = 0; i < 6 && flag[0] !== 1'b0; i++) tick(1);
    chk("flag", 16'h0002, {14'h0000, flag});
    ccs = 2'h0;
    fclr = 2'h3;
    tick(1);
    fclr = 2'h0;
    chk("flag irq", 16'h0000, {12'h000, flag, ch_irq});
    $display("test dma done");
  endtask : t_dma
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    t_reset();
    t_edge();
    t_center();
    t_dma();
    complete_run();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
